//--- include/tedr_consts.vh
`ifndef TEDR_CONSTS_VH
`define TEDR_CONSTS_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define TEDR_ADDR_INJECT        12'h000
`define TEDR_ADDR_PC_VIEW       12'h004
`define TEDR_ADDR_SNAPSHOT      12'h008
`define TEDR_ADDR_W             12

// ------------------------------------------------------------
// snapshot field positions
// ------------------------------------------------------------
`define TEDR_SNAP_EAU_V         31
`define TEDR_SNAP_EAU_N         30
`define TEDR_SNAP_EAU_C         29
`define TEDR_SNAP_EAU_Z         28
`define TEDR_SNAP_MD_V          27
`define TEDR_SNAP_MD_N          26
`define TEDR_SNAP_MD_C          25
`define TEDR_SNAP_MD_Z          24
`define TEDR_SNAP_TRANSITION_LATCH_ONE          23
`define TEDR_SNAP_TRANSITION_LATCH_TWO          22
`define TEDR_SNAP_MATCH_LATCH_ONE          21
`define TEDR_SNAP_MATCH_LATCH_TWO          20
`define TEDR_SNAP_LINK          19
`define TEDR_SNAP_SEMA          18
`define TEDR_SNAP_FM_HI         17
`define TEDR_SNAP_FM_LO         16
`define TEDR_SNAP_SRB           15
`define TEDR_SNAP_HSR_HI        14
`define TEDR_SNAP_HSR_LO        12
`define TEDR_SNAP_RES0          11
`define TEDR_SNAP_RES1          10
`define TEDR_SNAP_MEN1          9
`define TEDR_SNAP_MEN2          8
`define TEDR_SNAP_ITDL          7
`define TEDR_SNAP_INTERNAL_MATCH_ONE         6
`define TEDR_SNAP_INTERNAL_MATCH_TWO         5
`define TEDR_SNAP_PSS           4
`define TEDR_SNAP_FILTERED_INPUT_STATE          3
`define TEDR_SNAP_OUTPUT_PIN_STATE          2
`define TEDR_SNAP_OBE           1
`define TEDR_SNAP_SPARE         0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TEDR_RST_WORD           32'h0000_0000
`define TEDR_RST_HSR            3'h0

`endif

//--- src/tedr_debug_regs.v
// Overview of operation
// [R1] writes to the inject register while the engine runs are dropped silently
// [R2] halted write places the word on the microinstruction register and runs it
// [R3] injected thread-end instructions are flagged so the engine ignores them
// [R4] reading the inject register always returns zero
// [R5] counter view is read-only, shows the counter when halted, else zero
// [R6] flag snapshot is read-only, current channel flags when halted, else zero
// [R7] bits 31..28 show arithmetic unit overflow, negative, carry, zero
// [R8] bits 27..24 show multiply/divide overflow, negative, carry, zero
// [R9] bits 23..20 show branch-visible transition 1,2 and match 1,2 latches
// [R10] bit 19 shows a link event to the serviced channel
// [R11] bit 18 shows the channel semaphore flag
// [R12] bits 17..16 mirror the channel function mode field
// [R13] bit 15 shows the service request block flag
// [R14] bits 14..12 hold host request captured at entry point selection
// [R15] bits 11 and 10 show the two state resolution flags
// [R16] bits 9 and 8 show match enables for events one and two
// [R17] bits 7..5 show internal transition (merged) and internal match latches
// [R18] bits 4..1 show pin sampled, filtered input, output pin, drive enable
// [R19] bit 0 always reads zero
`timescale 1ns/1ps
`default_nettype none
`include "tedr_consts.vh"

module tedr_debug_regs #(
  parameter [31:0] END_MASK  = 32'hF000_0000,
  parameter [31:0] END_MATCH = 32'hF000_0000,
  parameter        PC_W      = 14
) (
  // clock, reset, enable
  input  wire                 core_clk,
  input  wire                 rst,
  input  wire                 ce,

  // apb slave
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [31:0]          paddr,
  input  wire [31:0]          pwdata,
  input  wire [3:0]           pstrb,
  output wire                 pready,
  output wire                 pslverr,
  output reg  [31:0]          prdata,

  // engine state
  input  wire                 engine_halted,
  input  wire [PC_W-1:0]      microprogram_counter,

  // microinstruction injection
  output reg  [31:0]          inject_word,
  output reg                  inject_exec,
  output reg                  inject_end_ignore,

  // arithmetic unit flags
  input  wire                 exec_arith_overflow,
  input  wire                 exec_arith_negative,
  input  wire                 exec_arith_carry,
  input  wire                 exec_arith_zero,

  // multiply/divide flags
  input  wire                 muldiv_overflow,
  input  wire                 muldiv_negative,
  input  wire                 muldiv_carry,
  input  wire                 muldiv_zero,

  // branch-visible latches
  input  wire                 transition_latch_one,
  input  wire                 transition_latch_two,
  input  wire                 match_latch_one,
  input  wire                 match_latch_two,

  // channel control flags
  input  wire                 link_service_flag,
  input  wire                 semaphore_flag,
  input  wire [1:0]           function_mode_bits,
  input  wire                 service_request_block,
  input  wire                 entry_point_select,
  input  wire [2:0]           host_request_live,
  input  wire                 state_resolution_bit_zero,
  input  wire                 state_resolution_bit_one,
  input  wire                 match_enable_one,
  input  wire                 match_enable_two,

  // internal latches
  input  wire                 internal_transition_one,
  input  wire                 internal_transition_two,
  input  wire                 internal_match_one,
  input  wire                 internal_match_two,

  // pin state
  input  wire                 pin_sampled_flag,
  input  wire                 filtered_input_state,
  input  wire                 output_pin_state,
  input  wire                 output_drive_enable
);

  // ------------------------------------------------------------
  // bus phase tracking
  // ------------------------------------------------------------
  // an access only completes after a setup cycle seen by this block;
  // a stray penable, e.g. from a master that ran on through a reset
  // of this block, then cannot fire an injection
  localparam BUS_IDLE   = 1'h0;
  localparam BUS_ACCESS = 1'h1;

  reg bus_state_reg;
  reg bus_state_next;

  always @*
  begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_IDLE:
      begin
        if (psel & ~penable)
        begin
          bus_state_next = BUS_ACCESS;
        end
      end
      BUS_ACCESS:
      begin
        if (psel & ~penable)
        begin
          // the master restarted with a fresh setup cycle
          bus_state_next = BUS_ACCESS;
        end
        else
        begin
          // completed with zero waits, or abandoned
          bus_state_next = BUS_IDLE;
        end
      end
    endcase
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_state_reg <= BUS_IDLE;
    end
    else if (ce)
    begin
      bus_state_reg <= bus_state_next;
    end
  end

  // ------------------------------------------------------------
  // bus phase decode
  // ------------------------------------------------------------
  wire [`TEDR_ADDR_W-1:0] addr_low;
  wire                    addr_hit_inject;
  wire                    addr_hit_pc;
  wire                    addr_hit_snap;
  wire                    addr_mapped;
  wire                    setup_phase;
  wire                    access_done;
  wire                    write_done;
  reg                     map_err_reg;

  assign addr_low    = paddr[`TEDR_ADDR_W-1:0];
  // upper address bits are ignored so the block aliases in its window
  assign addr_hit_inject = (addr_low == `TEDR_ADDR_INJECT);
  assign addr_hit_pc     = (addr_low == `TEDR_ADDR_PC_VIEW);
  assign addr_hit_snap   = (addr_low == `TEDR_ADDR_SNAPSHOT);
  assign addr_mapped = addr_hit_inject | addr_hit_pc | addr_hit_snap;

  assign setup_phase = ce & psel & ~penable;
  // zero wait states; a frozen block holds the master off
  assign pready      = ce;
  assign access_done = ce & psel & penable & (bus_state_reg == BUS_ACCESS);
  assign write_done  = access_done & pwrite;
  assign pslverr     = psel & penable & map_err_reg;

  // ------------------------------------------------------------
  // host request captured at entry point selection
  // ------------------------------------------------------------
  reg [2:0] entry_hsr_reg;
  reg [2:0] entry_hsr_next;

  always @*
  begin
    entry_hsr_next = entry_hsr_reg;
    // the live request may change mid-thread; only the chosen value counts
    if (entry_point_select)
    begin
      entry_hsr_next = host_request_live; // R14
    end
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      entry_hsr_reg <= `TEDR_RST_HSR;
    end
    else if (ce)
    begin
      entry_hsr_reg <= entry_hsr_next;
    end
  end

  // ------------------------------------------------------------
  // snapshot assembly
  // ------------------------------------------------------------
  reg [31:0] snap_word;

  always @*
  begin
    snap_word = `TEDR_RST_WORD;
    snap_word[`TEDR_SNAP_EAU_V] = exec_arith_overflow; // R7
    snap_word[`TEDR_SNAP_EAU_N] = exec_arith_negative; // R7
    snap_word[`TEDR_SNAP_EAU_C] = exec_arith_carry; // R7
    snap_word[`TEDR_SNAP_EAU_Z] = exec_arith_zero; // R7
    snap_word[`TEDR_SNAP_MD_V]  = muldiv_overflow; // R8
    snap_word[`TEDR_SNAP_MD_N]  = muldiv_negative; // R8
    snap_word[`TEDR_SNAP_MD_C]  = muldiv_carry; // R8
    snap_word[`TEDR_SNAP_MD_Z]  = muldiv_zero; // R8
    snap_word[`TEDR_SNAP_TRANSITION_LATCH_ONE]  = transition_latch_one; // R9
    snap_word[`TEDR_SNAP_TRANSITION_LATCH_TWO]  = transition_latch_two; // R9
    snap_word[`TEDR_SNAP_MATCH_LATCH_ONE]  = match_latch_one; // R9
    snap_word[`TEDR_SNAP_MATCH_LATCH_TWO]  = match_latch_two; // R9
    snap_word[`TEDR_SNAP_LINK]  = link_service_flag; // R10
    snap_word[`TEDR_SNAP_SEMA]  = semaphore_flag; // R11
    snap_word[`TEDR_SNAP_FM_HI:`TEDR_SNAP_FM_LO] = function_mode_bits; // R12
    snap_word[`TEDR_SNAP_SRB]   = service_request_block; // R13
    snap_word[`TEDR_SNAP_HSR_HI:`TEDR_SNAP_HSR_LO] = entry_hsr_reg; // R14
    snap_word[`TEDR_SNAP_RES0]  = state_resolution_bit_zero; // R15
    snap_word[`TEDR_SNAP_RES1]  = state_resolution_bit_one; // R15
    snap_word[`TEDR_SNAP_MEN1]  = match_enable_one; // R16
    snap_word[`TEDR_SNAP_MEN2]  = match_enable_two; // R16
    // both internal transition latches share one bit position, so or them
    snap_word[`TEDR_SNAP_ITDL]  = internal_transition_one
                                | internal_transition_two; // R17
    snap_word[`TEDR_SNAP_INTERNAL_MATCH_ONE] = internal_match_one; // R17
    snap_word[`TEDR_SNAP_INTERNAL_MATCH_TWO] = internal_match_two; // R17
    snap_word[`TEDR_SNAP_PSS]   = pin_sampled_flag; // R18
    snap_word[`TEDR_SNAP_FILTERED_INPUT_STATE]  = filtered_input_state; // R18
    snap_word[`TEDR_SNAP_OUTPUT_PIN_STATE]  = output_pin_state; // R18
    snap_word[`TEDR_SNAP_OBE]   = output_drive_enable; // R18
    snap_word[`TEDR_SNAP_SPARE] = 1'b0; // R19
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  reg [31:0] rd_next;

  always @*
  begin
    rd_next = `TEDR_RST_WORD;
    if (addr_hit_inject)
    begin
      rd_next = `TEDR_RST_WORD; // R4
    end
    else if (addr_hit_pc)
    begin
      if (engine_halted)
      begin
        rd_next[PC_W-1:0] = microprogram_counter; // R5
      end
    end
    else if (addr_hit_snap)
    begin
      if (engine_halted)
      begin
        rd_next = snap_word; // R6
      end
    end
  end

  // ------------------------------------------------------------
  // read data and error, loaded in the setup cycle
  // ------------------------------------------------------------
  // loading at setup keeps prdata a flop output and allows zero waits;
  // the value reflects engine state one edge before completion
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata      <= `TEDR_RST_WORD;
      map_err_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      map_err_reg <= ~addr_mapped;
      if (pwrite)
      begin
        prdata <= `TEDR_RST_WORD;
      end
      else
      begin
        prdata <= rd_next; // R6
      end
    end
  end

  // ------------------------------------------------------------
  // microinstruction injection
  // ------------------------------------------------------------
  wire inject_take;
  wire inject_is_end;

  // writes to the read-only views and unmapped writes change nothing
  assign inject_take   = write_done & addr_hit_inject & engine_halted; // R1
  assign inject_is_end = ((pwdata & END_MASK) == END_MATCH);

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      inject_word       <= `TEDR_RST_WORD;
      inject_exec       <= 1'b0;
      inject_end_ignore <= 1'b0;
    end
    else if (ce)
    begin
      inject_exec <= inject_take; // R2
      if (inject_take)
      begin
        // partial strobes still load the whole word: the engine needs
        // a complete instruction and has no read-back path to merge with
        inject_word       <= pwdata; // R2
        inject_end_ignore <= inject_is_end; // R3
      end
    end
  end

endmodule // tedr_debug_regs

`default_nettype wire

//--- test/tedr_apb_host.sv
`timescale 1ns/1ps
`default_nettype none
module tedr_apb_host (
  // clock
  input  wire logic        core_clk,
  // request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [31:0] paddr,
  output var  logic [31:0] pwdata,
  // answer
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  int tmo = 0;
  initial
  begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic wr, input logic [31:0] a, w,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      tmo++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show garbage, not the last value
    paddr <= ~a;
    pwdata <= ~w;
  endtask
endmodule // tedr_apb_host
`default_nettype wire

//--- test/tedr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tedr_checker #(parameter PC_W = 14) (
  // clock, reset
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // engine
  input wire logic        engine_halted,
  input wire logic [31:0] inject_word,
  input wire logic        inject_exec
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_acc;
    psel && penable && ce;
  endsequence
  sequence s_wr0;
    s_acc ##0 pwrite && paddr[11:0] == 12'h000;
  endsequence
  sequence s_rd(a);
    s_acc ##0 !pwrite && paddr[11:0] == a;
  endsequence
  a_wr_dropped: assert property (s_wr0 ##0 !engine_halted |=> !inject_exec)
    else $error("inject ran while engine active");
  a_wr_runs: assert property (s_wr0 ##0 engine_halted |=>
    inject_exec && inject_word == $past(pwdata)) else $error("inject not run");
  a_exec_pulse: assert property (inject_exec && ce |=> !inject_exec)
    else $error("inject pulse too long");
  a_inject_rdzero: assert property (s_rd(12'h000) |-> prdata == 32'h0000_0000)
    else $error("inject read not zero");
  a_view_runzero: assert property (s_rd(12'h004) ##0 !$past(engine_halted) |->
    prdata == 32'h0000_0000) else $error("counter view not zero");
  a_view_upper: assert property (s_rd(12'h004) |-> prdata[31:PC_W] == 0)
    else $error("counter view upper bits set");
  a_snap_runzero: assert property (s_rd(12'h008) ##0 !$past(engine_halted) |->
    prdata == 32'h0000_0000) else $error("snapshot not zero");
  a_snap_bitzero: assert property (s_rd(12'h008) |-> !prdata[0])
    else $error("snapshot bit 0 set");
endmodule // tedr_checker
bind tedr_debug_regs tedr_checker #(.PC_W(PC_W)) u_chk (.core_clk(core_clk), .rst(rst),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .engine_halted(engine_halted),
  .inject_word(inject_word), .inject_exec(inject_exec));
`default_nettype wire

//--- test/timing_engine_debug_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module timing_engine_debug_regs_test;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] fv = 32'h0000_0000;
  logic        itd2 = 1'b0;
  logic        eps = 1'b0;
  logic        halt = 1'b0;
  logic        ce = 1'b1;
  logic [13:0] pc = 14'h0000;
  wire         psel, penable, pwrite, pready, pslverr, iex, iend;
  wire  [31:0] paddr, pwdata, prdata, iword;
  logic [31:0] rv;
  logic        ev;
  int          failures = 0;
  int          num_checks = 0;
  always #2.5 core_clk = ~core_clk;
  tedr_apb_host host (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata));
  tedr_debug_regs uut (.core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .engine_halted(halt),
    .microprogram_counter(pc), .inject_word(iword), .inject_exec(iex),
    .inject_end_ignore(iend), .exec_arith_overflow(fv[31]), .exec_arith_negative(fv[30]),
    .exec_arith_carry(fv[29]), .exec_arith_zero(fv[28]), .muldiv_overflow(fv[27]),
    .muldiv_negative(fv[26]), .muldiv_carry(fv[25]), .muldiv_zero(fv[24]),
    .transition_latch_one(fv[23]), .transition_latch_two(fv[22]),
    .match_latch_one(fv[21]), .match_latch_two(fv[20]), .link_service_flag(fv[19]),
    .semaphore_flag(fv[18]), .function_mode_bits(fv[17:16]),
    .service_request_block(fv[15]), .entry_point_select(eps),
    .host_request_live(fv[14:12]), .state_resolution_bit_zero(fv[11]),
    .state_resolution_bit_one(fv[10]), .match_enable_one(fv[9]),
    .match_enable_two(fv[8]), .internal_transition_one(fv[7]),
    .internal_transition_two(itd2), .internal_match_one(fv[6]),
    .internal_match_two(fv[5]), .pin_sampled_flag(fv[4]),
    .filtered_input_state(fv[3]), .output_pin_state(fv[2]),
    .output_drive_enable(fv[1]));
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, g);
    num_checks++;
    if (g !== x)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, x, g);
    end
  endtask
  task xf(input logic wr, input logic [31:0] a, w);
    host.xfer(wr, a, w, rv, ev);
    if (host.tmo != 0)
    begin
      failures++;
      test_done();
    end
  endtask
  // entry pulse captures the host request field together with the flags
  task setf(input logic [31:0] v, input logic p);
    @(posedge core_clk);
    fv <= v;
    eps <= p;
    @(posedge core_clk);
    eps <= 1'b0;
  endtask
  task t_inject;
    halt <= 1'b1;
    xf(1'b1, 32'h0000_0000, 32'h1234_5678);
    #1 chk("inject pulse", 32'h0000_0001, iex);
    chk("inject word", 32'h1234_5678, iword);
    chk("end ignore", 32'h0000_0000, iend);
    xf(1'b1, 32'h0000_0000, 32'hF000_00A5);
    #1 chk("end ignore", 32'h0000_0001, iend);
    xf(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk("inject read", 32'h0000_0000, rv);
    halt <= 1'b0;
    xf(1'b1, 32'h0000_0000, 32'h0BAD_0001);
    #1 chk("dropped pulse", 32'h0000_0000, iex);
    chk("kept word", 32'hF000_00A5, iword);
  endtask
  task t_view;
    halt <= 1'b1;
    pc <= 14'h2A5C;
    xf(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
    xf(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk("counter view", 32'h0000_2A5C, rv);
    halt <= 1'b0;
    xf(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk("counter view run", 32'h0000_0000, rv);
  endtask
  task t_snap;
    halt <= 1'b1;
    for (int i = 1; i < 32; i++)
    begin
      setf(32'h0000_0001 << i, 1'b1);
      xf(1'b0, 32'h0000_0008, 32'h0000_0000);
      chk("snapshot bit", 32'h0000_0001 << i, rv);
    end
    itd2 <= 1'b1;
    setf(32'h0000_5000, 1'b1);
    setf(32'h0000_2000, 1'b0);
    xf(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk("entry request", 32'h0000_5080, rv);
    setf(32'hFFFF_FFFF, 1'b1);
    xf(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk("snapshot all", 32'hFFFF_FFFE, rv);
    xf(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, ev);
    chk("unmapped read", 32'h0000_0000, rv);
    halt <= 1'b0;
    xf(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk("snapshot run", 32'h0000_0000, rv);
  endtask
  // a low enable must freeze the captured request field and stall the bus
  task t_freeze;
    halt <= 1'b1;
    ce <= 1'b0;
    setf(32'h0000_3000, 1'b1);
    #1 chk("pready frozen", 32'h0000_0000, pready);
    @(posedge core_clk);
    ce <= 1'b1;
    xf(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk("frozen entry request", 32'h0000_7080, rv);
    chk("pready running", 32'h0000_0001, pready);
  endtask
  // mid-run reset clears the injection outputs; the bus is usable at once
  task t_reset;
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    #1 chk("reset word", 32'h0000_0000, iword);
    chk("reset end ignore", 32'h0000_0000, iend);
    chk("reset read data", 32'h0000_0000, prdata);
    @(posedge core_clk);
    rst <= 1'b0;
    xf(1'b1, 32'h0000_0000, 32'hF000_0001);
    #1 chk("inject after reset", 32'h0000_0001, iex);
    chk("end after reset", 32'h0000_0001, iend);
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_inject();
    t_view();
    t_snap();
    t_freeze();
    t_reset();
    test_done();
  end
endmodule // timing_engine_debug_regs_test
`default_nettype wire
